// [verilog/wave_timer.sv]
/*
 Waveform side of an 8-bit timer/counter with a compare output unit,
 reached over AHB-Lite. Assumes one master, single word transfers, and a
 timer clock enable bit held in a register in place of a prescaler.
*/
// Register access over AHB-Lite and the register offsets were decided locally.
module wave_timer
    import wave_timer_pkg::*;
(
    input wire logic core_clk, // System clock, 125 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic pinOut, // Waveform pin level
    output logic pinOe // Waveform pin drive enable
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    bus_req_t req_r; // Address phase held for data phase
    wave_mode_t waveSel_r; // Waveform select
    logic [1:0] outSel_r; // Compare output select
    logic [7:0] countValue_r; // Counter
    logic [7:0] compareValue_r; // Active compare value
    logic [7:0] compareBuf_r; // Buffer for PWM modes
    logic outBit_r; // Internal compare output bit
    logic wrapFlag_r; // Overflow flag
    logic matchFlag_r; // Compare match flag
    logic portValue_r; // Normal port output value
    logic pinDir_r; // Pin direction
    logic tickEn_r; // Timer clock enable
    logic blockMatch_r; // Count write blocks next tick's match
    logic matchPend_r; // Match seen, flag follows next tick
    logic [31:0] hrdata_r; // Read data register
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic wrNow; // Data phase of a write
    logic wrCtl, wrCnt, wrCmp, wrFlg, wrPin; // Per-register write
    logic isPwm; // Buffered compare modes
    logic atMatch; // Comparator equality, not blocked
    logic forceHit; // Force strobe in non-PWM mode
    logic [1:0] actSel; // Written select for a force, so one write presets the bit
    logic [1:0] modeBits; // Written mode field
    always_comb
    begin
        wrNow = req_r.valid && req_r.write;
        wrCtl = wrNow && (req_r.addr == OFF_CONTROL);
        wrCnt = wrNow && (req_r.addr == OFF_COUNT);
        wrCmp = wrNow && (req_r.addr == OFF_COMPARE);
        wrFlg = wrNow && (req_r.addr == OFF_FLAGS);
        wrPin = wrNow && (req_r.addr == OFF_PIN);
        isPwm = (waveSel_r == WAVE_FAST_PWM) || (waveSel_r == WAVE_PHASE);
        atMatch = tickEn_r && !blockMatch_r && (countValue_r == compareValue_r);
        modeBits = hwdata[CTL_WAVE_LO +: 2];
        forceHit = wrCtl && hwdata[CTL_FORCE]
            && (modeBits != WAVE_FAST_PWM) && (modeBits != WAVE_PHASE);
        actSel = forceHit ? hwdata[CTL_SEL_LO +: 2] : outSel_r;
    end
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Zero wait states: every data phase completes in one cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            req_r <= '0;
        end
        else if (hready)
        begin
            req_r.valid <= hsel && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);
            req_r.write <= hwrite;
            req_r.addr <= haddr[7:0];
        end
    end
    // Read data captured at the address phase, so it stands in the data phase
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            hrdata_r <= BUS_ZERO;
        end
        else if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite)
        begin
            hrdata_r <= BUS_ZERO;
            if (haddr[7:0] == OFF_CONTROL)
            begin
                hrdata_r[CTL_WAVE_LO +: 2] <= waveSel_r;
                hrdata_r[CTL_SEL_LO +: 2] <= outSel_r;
                hrdata_r[CTL_OUTBIT] <= outBit_r; // Force reads zero
            end
            else if (haddr[7:0] == OFF_COUNT)
            begin
                hrdata_r[7:0] <= countValue_r;
            end
            else if (haddr[7:0] == OFF_COMPARE)
            begin
                // Software sees the value it wrote, buffered or not
                hrdata_r[7:0] <= isPwm ? compareBuf_r : compareValue_r;
            end
            else if (haddr[7:0] == OFF_FLAGS)
            begin
                hrdata_r[FLG_WRAP] <= wrapFlag_r;
                hrdata_r[FLG_MATCH] <= matchFlag_r;
            end
            else if (haddr[7:0] == OFF_PIN)
            begin
                hrdata_r[PIN_PORT] <= portValue_r;
                hrdata_r[PIN_DIR] <= pinDir_r;
                hrdata_r[PIN_TICK] <= tickEn_r;
            end
        end
    end
    // Answer is constant: always ready, always OKAY
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = hrdata_r;
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Select change takes effect at once, no buffering
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            waveSel_r <= WAVE_NORMAL;
            outSel_r <= SEL_NONE;
            portValue_r <= 1'b0;
            pinDir_r <= 1'b0;
            tickEn_r <= 1'b0;
        end
        else
        begin
            if (wrCtl)
            begin
                waveSel_r <= wave_mode_t'(modeBits);
                outSel_r <= hwdata[CTL_SEL_LO +: 2];
            end
            if (wrPin)
            begin
                portValue_r <= hwdata[PIN_PORT];
                pinDir_r <= hwdata[PIN_DIR];
                tickEn_r <= hwdata[PIN_TICK];
            end
        end
    end
    // ----------------------------------------
    // Compare value and buffer
    // ----------------------------------------
    // PWM writes land in the buffer, copied to the comparator at top
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            compareValue_r <= COUNT_BOTTOM;
            compareBuf_r <= COUNT_BOTTOM;
        end
        else
        begin
            if (wrCmp)
            begin
                compareBuf_r <= hwdata[7:0];
            end
            if (wrCmp && !isPwm)
            begin
                compareValue_r <= hwdata[7:0];
            end
            else if (isPwm && tickEn_r && countValue_r == COUNT_MAX)
            begin
                compareValue_r <= compareBuf_r;
            end
        end
    end
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // CPU write wins over counting; the written value blocks one match
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            countValue_r <= COUNT_BOTTOM;
            blockMatch_r <= 1'b0;
        end
        else
        begin
            if (wrCnt)
            begin
                countValue_r <= hwdata[7:0];
            end
            else if (tickEn_r)
            begin
                if (waveSel_r == WAVE_CLEAR_MATCH && atMatch)
                begin
                    countValue_r <= COUNT_BOTTOM;
                end
                else
                begin
                    // Normal, fast PWM and missed compare all wrap at max
                    countValue_r <= countValue_r + 8'h01;
                end
            end
            if (wrCnt)
            begin
                blockMatch_r <= 1'b1;
            end
            else if (tickEn_r)
            begin
                blockMatch_r <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Flags
    // ----------------------------------------
    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wrapFlag_r <= 1'b0;
            matchFlag_r <= 1'b0;
            matchPend_r <= 1'b0;
        end
        else
        begin
            if (tickEn_r && countValue_r == COUNT_MAX && !wrCnt)
            begin
                wrapFlag_r <= 1'b1;
            end
            else if (wrFlg && hwdata[FLG_WRAP])
            begin
                wrapFlag_r <= 1'b0;
            end
            // Equality seen now sets the flag on the next tick
            if (atMatch)
            begin
                matchPend_r <= 1'b1;
            end
            else if (tickEn_r)
            begin
                matchPend_r <= 1'b0;
            end
            if (tickEn_r && matchPend_r)
            begin
                matchFlag_r <= 1'b1;
            end
            else if (wrFlg && hwdata[FLG_MATCH])
            begin
                matchFlag_r <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Compare output bit
    // ----------------------------------------
    // Kept across mode changes; force never touches flags or counter
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            outBit_r <= 1'b0;
        end
        else if (waveSel_r == WAVE_FAST_PWM && !forceHit)
        begin
            if (atMatch && outSel_r == SEL_CLEAR)
            begin
                outBit_r <= 1'b0;
            end
            else if (atMatch && outSel_r == SEL_SET)
            begin
                outBit_r <= 1'b1;
            end
            else if (atMatch && outSel_r == SEL_TOGGLE)
            begin
                outBit_r <= !outBit_r;
            end
            else if (tickEn_r && countValue_r == COUNT_MAX && outSel_r[1])
            begin
                // Restart at bottom restores the idle polarity
                outBit_r <= (outSel_r == SEL_CLEAR);
            end
        end
        else if (forceHit || (atMatch && !isPwm))
        begin
            if (actSel == SEL_TOGGLE)
            begin
                outBit_r <= !outBit_r;
            end
            else if (actSel == SEL_CLEAR)
            begin
                outBit_r <= 1'b0;
            end
            else if (actSel == SEL_SET)
            begin
                outBit_r <= 1'b1;
            end
            else
            begin
                outBit_r <= outBit_r;
            end
        end
    end
    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // Override depends only on the select field, direction still rules
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end
        else
        begin
            pinOut <= (outSel_r != SEL_NONE) ? outBit_r : portValue_r;
            pinOe <= pinDir_r;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_pin_override: assert property (@(posedge core_clk) disable iff (!nrst)
        (outSel_r != SEL_NONE) |=> (pinOut == $past(outBit_r)))
        else $error("pin does not follow output bit");
    a_pin_direction: assert property (@(posedge core_clk) disable iff (!nrst)
        1'b1 |=> (pinOe == $past(pinDir_r)))
        else $error("pin enable not from direction");
    a_normal_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
        (waveSel_r == WAVE_NORMAL && tickEn_r && !wrCnt && countValue_r == COUNT_MAX)
        |=> (countValue_r == COUNT_BOTTOM && wrapFlag_r))
        else $error("normal mode wrap wrong");
    a_ctc_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (waveSel_r == WAVE_CLEAR_MATCH && atMatch && !wrCnt) |=> (countValue_r == COUNT_BOTTOM))
        else $error("clear on match failed");
    a_match_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (atMatch && !wrFlg) ##1 (tickEn_r && !wrFlg) |=> matchFlag_r)
        else $error("match flag not set");
    a_zero_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (outSel_r == SEL_NONE && waveSel_r != WAVE_FAST_PWM && !forceHit) |=> $stable(outBit_r))
        else $error("output bit moved with select zero");
    a_force_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
        (forceHit && actSel == SEL_TOGGLE) |=> (outBit_r != $past(outBit_r)))
        else $error("force did not toggle");
    a_force_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        (forceHit && !atMatch && !matchPend_r && !matchFlag_r) |=> !matchFlag_r)
        else $error("force set the match flag");
    a_pwm_load: assert property (@(posedge core_clk) disable iff (!nrst)
        (isPwm && tickEn_r && countValue_r == COUNT_MAX) |=> (compareValue_r == $past(compareBuf_r)))
        else $error("buffer not loaded at top");
endmodule // wave_timer

// [verilog/wave_timer_pkg.sv]
/*
 Package for the 8-bit waveform timer: register offsets, field layouts,
 mode and action encodings, reset values.
 Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
*/
package wave_timer_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00; // Mode, action, force
    localparam logic [7:0] OFF_COUNT = 8'h04; // Counter value
    localparam logic [7:0] OFF_COMPARE = 8'h08; // Compare value
    localparam logic [7:0] OFF_FLAGS = 8'h0c; // Wrap and match flags
    localparam logic [7:0] OFF_PIN = 8'h10; // Port value, direction, tick
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL_WAVE_LO = 0; // Waveform select, 2 bits
    localparam int CTL_SEL_LO = 2; // Output action select, 2 bits
    localparam int CTL_FORCE = 4; // Force strobe, reads zero
    localparam int CTL_OUTBIT = 5; // Read-only compare output bit
    localparam int FLG_WRAP = 0; // Wrap flag
    localparam int FLG_MATCH = 1; // Match flag
    localparam int PIN_PORT = 0; // Normal port output value
    localparam int PIN_DIR = 1; // Pin direction, one is output
    localparam int PIN_TICK = 2; // Timer clock enable, one runs
    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [7:0] COUNT_MAX = 8'hff; // Top of the 8-bit range
    localparam logic [7:0] COUNT_BOTTOM = 8'h00; // Bottom of the range
    localparam logic [1:0] SEL_NONE = 2'h0; // Leave output alone
    localparam logic [1:0] SEL_TOGGLE = 2'h1; // Toggle on match
    localparam logic [1:0] SEL_CLEAR = 2'h2; // Clear on match
    localparam logic [1:0] SEL_SET = 2'h3; // Set on match
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000; // Read of unmapped word
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // AHB transfer type
    typedef enum logic [1:0] {
        WAVE_NORMAL,
        WAVE_PHASE,
        WAVE_CLEAR_MATCH,
        WAVE_FAST_PWM
    } wave_mode_t;
    // Latched address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_req_t;
endpackage

// [test/pin_pad_model.sv]
/*
 Pad model for the waveform pin: the port driver and its direction logic.
 Assumes the timer gives a pin level and a drive enable, both registered.
*/
module pin_pad_model
(
    input wire logic core_clk, // System clock
    input wire logic pinOut, // Level offered by the timer
    input wire logic pinOe, // Drive enable, high drives
    output logic padLevel // Level seen on the pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Pad resolution
    // ----------------------------------------
    logic lastDrv_r = 1'b0; // Last level actually driven
    // Remember the driven level so a floating pad can show its inverse
    always_ff @(posedge core_clk)
    begin
        if (pinOe)
        begin
            lastDrv_r <= pinOut;
        end
    end
    // Undriven pad has no pull: show inverse so stale values never pass
    assign padLevel = pinOe ? pinOut : ~lastDrv_r;
endmodule // pin_pad_model

// [test/tb_wave_timer.sv]
/*
 Self-checking bench for the waveform timer: bus tasks, a reset test, a table of pin
 waveform cases, then constant level, force, flag, clear-on-match and mid-run reset tests.
 Assumes a zero-wait AHB-Lite slave and the pad model beside it.
*/
module tb_wave_timer;
    import wave_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'b0; // 125 MHz clock
    logic nrst = 1'b0; // Reset, active low
    logic hsel = 1'b0, hwrite = 1'b0; // Bus select and direction
    logic [31:0] haddr = 32'h0, hwdata = 32'h0; // Address and write data
    logic [1:0] htrans = 2'h0; // Transfer type
    logic [2:0] hsize = 3'h2; // Word transfers only
    logic [31:0] hrdata; // Read data
    logic hreadyout, hresp, pinOut, pinOe, padLevel; // Outputs
    int n_mismatch = 0, samples_checked = 0, cyc = 0; // Counters
    int hi, lo, i, edges; // Measured figures
    logic [31:0] rd; // Last read word
    typedef struct {logic [1:0] mode; logic [1:0] sel; logic [7:0] cmp; int hi; int lo;} row_t;
    // Mode, action, compare, expected high and low run lengths
    row_t rows [7] = '{
        '{WAVE_CLEAR_MATCH, SEL_TOGGLE, 8'h04, 5, 5}, // Toggle period 2(1+4)
        '{WAVE_CLEAR_MATCH, SEL_TOGGLE, 8'h00, 1, 1}, // Fastest toggle
        '{WAVE_FAST_PWM, SEL_CLEAR, 8'h09, 10, 246}, // Non-inverted
        '{WAVE_FAST_PWM, SEL_SET, 8'h09, 246, 10}, // Inverted
        '{WAVE_FAST_PWM, SEL_CLEAR, 8'h00, 1, 255}, // Bottom spike
        '{WAVE_FAST_PWM, SEL_TOGGLE, 8'h05, 256, 256}, // Toggle each period
        '{WAVE_NORMAL, SEL_TOGGLE, 8'h10, 256, 256} // Free-running wrap
    };
    always #4 core_clk = ~core_clk;
    wave_timer dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pinOut(pinOut), .pinOe(pinOe));
    pin_pad_model pad (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .padLevel(padLevel));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One AHB-Lite single word transfer, held until hready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    // Stop timer, load count zero, compare and mode, then run with pin out
    task automatic setup(input logic [1:0] m, input logic [1:0] s, input logic [7:0] c);
        xfer(1'b1, OFF_PIN, 32'h2);
        xfer(1'b1, OFF_COUNT, 32'h0);
        xfer(1'b1, OFF_COMPARE, {24'h0, c});
        xfer(1'b1, OFF_CONTROL, {28'h0, s, m});
        xfer(1'b1, OFF_PIN, 32'h6);
    endtask
    // Wait for a rising pad edge, then time one high and one low run
    task automatic measure();
        int k;
        k = 0;
        do @(negedge core_clk); while (padLevel !== 1'b0 && ++k < 600);
        do @(negedge core_clk); while (padLevel !== 1'b1 && ++k < 1200);
        hi = 0;
        lo = 0;
        while (padLevel === 1'b1 && hi < 600)
        begin
            hi++;
            @(negedge core_clk);
        end
        while (padLevel === 1'b0 && lo < 600)
        begin
            lo++;
            @(negedge core_clk);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, well above the expected run of about 9000 cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        chk({hreadyout, hresp, pinOut, pinOe}, 4'h8, "reset outputs");
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h0, "reset control");
        $display("test reset done");
        // Table of waveform cases; second period avoids the buffered load
        for (i = 0; i < 7; i++)
        begin
            setup(rows[i].mode, rows[i].sel, rows[i].cmp);
            measure();
            measure();
            chk(hi, rows[i].hi, "high run");
            chk(lo, rows[i].lo, "low run");
        end
        $display("test waveform table done");
        // Compare at max in fast PWM gives a constant level
        setup(WAVE_FAST_PWM, SEL_CLEAR, 8'hff);
        // First top clears the bit; match beats the bottom set, so it stays low
        repeat (300) @(negedge core_clk);
        edges = 0;
        repeat (600)
        begin
            @(negedge core_clk);
            edges += (padLevel !== 1'b0);
        end
        repeat (600) @(negedge core_clk) if (pad.lastDrv_r !== padLevel) edges++;
        chk(edges, 0, "constant level");
        $display("test constant level done");
        // Force with timer stopped: output bit only, then override checks
        xfer(1'b1, OFF_PIN, 32'h0);
        xfer(1'b1, OFF_CONTROL, 32'h0);
        xfer(1'b1, OFF_FLAGS, 32'h3);
        xfer(1'b1, OFF_COUNT, 32'h33);
        xfer(1'b1, OFF_CONTROL, 32'h1c);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h2c, "forced set");
        xfer(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h0, "force flags");
        xfer(1'b0, OFF_COUNT, 32'h0);
        chk(rd, 32'h33, "force count");
        chk(pinOe, 1'b0, "input pin");
        xfer(1'b1, OFF_PIN, 32'h2);
        repeat (3) @(negedge core_clk);
        chk({pinOe, padLevel}, 2'h3, "override");
        xfer(1'b1, OFF_CONTROL, 32'h10);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h20, "select zero force");
        repeat (3) @(negedge core_clk);
        chk(padLevel, 1'b0, "port value");
        xfer(1'b1, OFF_CONTROL, 32'h14);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h04, "forced toggle");
        xfer(1'b1, OFF_CONTROL, 32'h14);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h24, "toggle back");
        xfer(1'b1, OFF_CONTROL, 32'h1b);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h2b, "force in PWM");
        xfer(1'b1, OFF_CONTROL, 32'h1b);
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h2b, "force ignored in PWM");
        repeat (3) @(negedge core_clk);
        chk(padLevel, 1'b1, "override in PWM");
        $display("test force done");
        // Normal mode wrap and match flags, cleared by writing ones
        xfer(1'b1, OFF_CONTROL, 32'h0);
        xfer(1'b1, OFF_COMPARE, 32'h1);
        xfer(1'b1, OFF_COUNT, 32'hfe);
        xfer(1'b1, OFF_PIN, 32'h4);
        repeat (10) @(posedge core_clk);
        xfer(1'b1, OFF_PIN, 32'h0);
        xfer(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h3, "normal flags");
        xfer(1'b0, OFF_COUNT, 32'h0);
        chk(rd > 32'h5 && rd < 32'h1f, 1'b1, "wrapped count");
        xfer(1'b1, OFF_FLAGS, 32'h3);
        xfer(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h0, "flags cleared");
        $display("test normal flags done");
        // Clear-on-match with compare below count must wrap first
        xfer(1'b1, OFF_CONTROL, 32'h2);
        xfer(1'b1, OFF_COUNT, 32'h50);
        xfer(1'b1, OFF_COMPARE, 32'h10);
        xfer(1'b1, OFF_PIN, 32'h4);
        repeat (20) @(posedge core_clk);
        xfer(1'b0, OFF_COUNT, 32'h0);
        chk(rd > 32'h50, 1'b1, "missed match");
        xfer(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h0, "no early flags");
        repeat (250) @(posedge core_clk);
        xfer(1'b1, OFF_PIN, 32'h0);
        xfer(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h3, "wrap then match");
        xfer(1'b0, 8'h20, 32'h0);
        chk(rd, BUS_ZERO, "unmapped read");
        $display("test clear on match done");
        // Reset in mid-run clears the output bit that survived the mode changes
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h22, "bit kept over modes");
        nrst <= 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        xfer(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h0, "mid-run reset");
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // tb_wave_timer
